// >>> ddr_sram_pkg.sv
// constants shared by the burst-of-four common-io memory port
// assumes: one device configuration, 36 data bits in four 9-bit lanes
`default_nettype none

package ddr_sram_pkg;
  localparam int DQ_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int ADDR_W = 20;
  localparam int BURST_LEN = 4;
  // first read beat, in half cycles of the main clock after the command
  localparam int RD_FIRST_HALF_CYC = 3;
  // write beats follow the command by this many cycles
  localparam int WR_DATA_DELAY_CYC = 1;
  localparam int LOCK_W = 10;
  // delay line settle count in sys_clk cycles
  localparam logic [LOCK_W-1:0] DLL_LOCK_CYC = 10'h200;
  localparam logic [1:0] PAIR_LO_OFS = 2'h0;
  localparam logic [1:0] PAIR_HI_OFS = 2'h2;
  localparam logic [1:0] NEXT_OFS = 2'h1;
endpackage

`default_nettype wire

// >>> mem_port_if.sv
// paired write and read port between the link logic and the cell array
// assumes: both ends clocked by the main link clock
`default_nettype none

interface mem_port_if;
  logic we;
  logic [ddr_sram_pkg::ADDR_W-1:0] waA;
  logic [ddr_sram_pkg::ADDR_W-1:0] waB;
  logic [ddr_sram_pkg::ADDR_W-1:0] raA;
  logic [ddr_sram_pkg::ADDR_W-1:0] raB;
  logic [ddr_sram_pkg::DQ_W-1:0] wdA;
  logic [ddr_sram_pkg::DQ_W-1:0] wdB;
  logic [ddr_sram_pkg::LANES-1:0] beA;
  logic [ddr_sram_pkg::LANES-1:0] beB;
  logic [ddr_sram_pkg::DQ_W-1:0] rdA;
  logic [ddr_sram_pkg::DQ_W-1:0] rdB;

  modport ctrl (output we, waA, waB, raA, raB, wdA, wdB, beA, beB, input rdA, rdB);
  modport array (input we, waA, waB, raA, raB, wdA, wdB, beA, beB, output rdA, rdB);
endinterface

`default_nettype wire

// >>> sram_array.sv
// cell array: two byte-masked write ports, two registered read ports
// assumes: addresses of a pair never collide; read returns old data on a
// same-edge write
`default_nettype none

module sram_array (
  input wire logic kClk,
  mem_port_if.array mp
);
  import ddr_sram_pkg::*;

  logic [DQ_W-1:0] cells [0:(1<<ADDR_W)-1];
  logic [DQ_W-1:0] rdA_r;
  logic [DQ_W-1:0] rdB_r;

  always_ff @(posedge kClk) begin
    for (int j = 0; j < LANES; j++) begin
      // each lane enable gates its own 9 data bits
      if (mp.we && mp.beA[j]) begin
        cells[mp.waA][j*LANE_W +: LANE_W] <= mp.wdA[j*LANE_W +: LANE_W];
      end
      if (mp.we && mp.beB[j]) begin
        cells[mp.waB][j*LANE_W +: LANE_W] <= mp.wdB[j*LANE_W +: LANE_W];
      end
    end
    rdA_r <= cells[mp.raA];
    rdB_r <= cells[mp.raB];
  end

  assign mp.rdA = rdA_r;
  assign mp.rdB = rdB_r;
endmodule // sram_array

`default_nettype wire

// >>> ddr_burst4_cio_sram_port.sv
// burst-of-four double data rate common-io memory, pin side
// assumes: complementary main clock is the exact inverse of kClk; the
// controller keeps commands two cycles apart and releases the bus on reads
`default_nettype none

module ddr_burst4_cio_sram_port (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic kClk,
  input wire logic outClk,
  input wire logic outClkN,
  input wire logic dllDisable_n,
  input wire logic rwSelect,
  input wire logic loadStrobe_n,
  input wire logic [ddr_sram_pkg::ADDR_W-3:0] addressInputs,
  input wire logic burstStartAddrLsb,
  input wire logic burstStartAddrMsb,
  input wire logic [ddr_sram_pkg::LANES-1:0] byteWriteEnable_n,
  input wire logic [ddr_sram_pkg::DQ_W-1:0] dqIn,
  output logic [ddr_sram_pkg::DQ_W-1:0] dqOut,
  output logic dqOe,
  output logic echoTimingOut,
  output logic echoTimingOutN,
  output logic dllLocked
);
  import ddr_sram_pkg::*;

  function automatic logic [ADDR_W-1:0] burstWord(input logic [ADDR_W-1:0] base,
                                                  input logic [1:0] k);
    logic [1:0] idx;
    idx = 2'(base[1:0] + k);
    // linear wrap inside the four-word group
    burstWord = {base[ADDR_W-1:2], idx};
  endfunction

  ////////////////////////////////////////////////////////////
  // delay loop enable and settle, system clock

  logic dllOffS1_r;
  logic dllOffS2_r;
  logic dllEn_r;
  logic dllLocked_r;
  logic readySys_r;
  logic [LOCK_W-1:0] lockCnt_r;
  logic [LOCK_W-1:0] lockCnt_nxt;
  logic dllLocked_nxt;
  logic readySys_nxt;

  assign lockCnt_nxt = !dllEn_r ? '0 :
                       (lockCnt_r == DLL_LOCK_CYC) ? lockCnt_r :
                       lockCnt_r + 1'b1;
  assign dllLocked_nxt = dllEn_r && (lockCnt_r == DLL_LOCK_CYC);
  // with the loop off the part still runs, just with a narrower eye
  assign readySys_nxt = !dllEn_r || dllLocked_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      // loop taken as on until the pin says otherwise, so ready cannot blip
      dllOffS1_r <= 1'b1;
      dllOffS2_r <= 1'b1;
      dllEn_r <= 1'b1;
      lockCnt_r <= '0;
      dllLocked_r <= 1'b0;
      readySys_r <= 1'b0;
    end else begin
      dllOffS1_r <= dllDisable_n;
      dllOffS2_r <= dllOffS1_r;
      dllEn_r <= dllOffS2_r;
      lockCnt_r <= lockCnt_nxt;
      dllLocked_r <= dllLocked_nxt;
      readySys_r <= readySys_nxt;
    end
  end

  assign dllLocked = dllLocked_r;

  ////////////////////////////////////////////////////////////
  // crossings into the link domain

  logic kRstS1_r;
  logic kRstS2_r;
  logic kRst_b;
  logic readyS1_r;
  logic readyS2_r;
  logic cS1_r;
  logic cS2_r;
  logic cnS1_r;
  logic cnS2_r;
  logic cTied_r;

  always_ff @(posedge kClk) begin
    kRstS1_r <= rst_b;
    kRstS2_r <= kRstS1_r;
  end

  assign kRst_b = kRstS2_r;

  always_ff @(posedge kClk) begin
    if (!kRst_b) begin
      readyS1_r <= 1'b0;
      readyS2_r <= 1'b0;
      cS1_r <= 1'b0;
      cS2_r <= 1'b0;
      cnS1_r <= 1'b0;
      cnS2_r <= 1'b0;
      cTied_r <= 1'b0;
    end else begin
      readyS1_r <= readySys_r;
      readyS2_r <= readyS1_r;
      cS1_r <= outClk;
      cS2_r <= cS1_r;
      cnS1_r <= outClkN;
      cnS2_r <= cnS1_r;
      cTied_r <= cS2_r && cnS2_r;
    end
  end

  ////////////////////////////////////////////////////////////
  // command capture

  logic rdP1_r;
  logic rdP2_r;
  logic rdP3_r;
  logic wrP1_r;
  logic wrP2_r;
  logic wrP3_r;
  logic [ADDR_W-1:0] rdAddr_r;
  logic [ADDR_W-1:0] wrAddr_r;
  logic [ADDR_W-1:0] wrAddrHi_r;
  logic busy;
  logic cmdTake;
  logic rdAcc;
  logic wrAcc;
  logic [ADDR_W-1:0] pinAddr;

  // one cycle after a load the data bus is still busy with its burst
  assign busy = rdP1_r || wrP1_r;
  assign cmdTake = readyS2_r && !loadStrobe_n && !busy;
  assign rdAcc = cmdTake && rwSelect;
  assign wrAcc = cmdTake && !rwSelect;
  assign pinAddr = {addressInputs, burstStartAddrMsb, burstStartAddrLsb};

  always_ff @(posedge kClk) begin
    if (!kRst_b) begin
      rdP1_r <= 1'b0;
      rdP2_r <= 1'b0;
      rdP3_r <= 1'b0;
      wrP1_r <= 1'b0;
      wrP2_r <= 1'b0;
      wrP3_r <= 1'b0;
    end else begin
      rdP1_r <= rdAcc;
      rdP2_r <= rdP1_r;
      rdP3_r <= rdP2_r;
      wrP1_r <= wrAcc;
      wrP2_r <= wrP1_r;
      wrP3_r <= wrP2_r;
    end
  end

  always_ff @(posedge kClk) begin
    if (!kRst_b) begin
      rdAddr_r <= '0;
      wrAddr_r <= '0;
      wrAddrHi_r <= '0;
    end else begin
      if (rdAcc) begin
        rdAddr_r <= pinAddr;
      end
      if (wrAcc) begin
        wrAddr_r <= pinAddr;
      end
      // a write taken two cycles on reloads wrAddr_r before beats 3,4 land
      if (wrP2_r) begin
        wrAddrHi_r <= wrAddr_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // write beats: 1,3 on the rising edge, 2,4 on the falling edge

  logic [DQ_W-1:0] wPos_r;
  logic [DQ_W-1:0] wNeg_r;
  logic [LANES-1:0] bePos_r;
  logic [LANES-1:0] beNeg_r;

  always_ff @(posedge kClk) begin
    if (!kRst_b) begin
      wPos_r <= '0;
      bePos_r <= '0;
    end else if (wrP1_r || wrP2_r) begin
      wPos_r <= dqIn;
      bePos_r <= ~byteWriteEnable_n;
    end
  end

  always_ff @(negedge kClk) begin
    if (!kRst_b) begin
      wNeg_r <= '0;
      beNeg_r <= '0;
    end else if (wrP2_r || wrP3_r) begin
      wNeg_r <= dqIn;
      beNeg_r <= ~byteWriteEnable_n;
    end
  end

  ////////////////////////////////////////////////////////////
  // array access, two words per rising edge

  mem_port_if mp ();

  sram_array u_array (
    .kClk(kClk),
    .mp(mp.array)
  );

  logic [1:0] wrOfsA;
  logic [1:0] wrOfsB;
  logic [1:0] rdOfsA;
  logic [1:0] rdOfsB;
  logic [ADDR_W-1:0] wrBase;

  assign wrOfsA = wrP3_r ? PAIR_HI_OFS : PAIR_LO_OFS;
  assign wrOfsB = wrOfsA + NEXT_OFS;
  assign rdOfsA = rdP1_r ? PAIR_HI_OFS : PAIR_LO_OFS;
  assign rdOfsB = rdOfsA + NEXT_OFS;

  // beats 1,2 land at cycle 2, beats 3,4 at cycle 3: always four words
  assign mp.we = wrP2_r || wrP3_r;
  assign wrBase = wrP3_r ? wrAddrHi_r : wrAddr_r;
  assign mp.waA = burstWord(wrBase, wrOfsA);
  assign mp.waB = burstWord(wrBase, wrOfsB);
  assign mp.wdA = wPos_r;
  assign mp.wdB = wNeg_r;
  assign mp.beA = bePos_r;
  assign mp.beB = beNeg_r;
  // first pair read straight off the pins so beat 1 makes 1.5 cycles
  assign mp.raA = rdP1_r ? burstWord(rdAddr_r, rdOfsA) : burstWord(pinAddr, rdOfsA);
  assign mp.raB = rdP1_r ? burstWord(rdAddr_r, rdOfsB) : burstWord(pinAddr, rdOfsB);

  ////////////////////////////////////////////////////////////
  // read launch

  logic [DQ_W-1:0] hold0_r;
  logic [DQ_W-1:0] hold1_r;
  logic [DQ_W-1:0] dqPos_r;
  logic [DQ_W-1:0] dqNeg_r;
  logic dqOe_r;
  logic rdDrive;

  assign rdDrive = rdP2_r || rdP3_r;

  always_ff @(posedge kClk) begin
    if (!kRst_b) begin
      hold0_r <= '0;
      hold1_r <= '0;
    end else if (rdP1_r || rdP2_r) begin
      hold0_r <= mp.rdA;
      hold1_r <= mp.rdB;
    end
  end

  always_ff @(posedge kClk) begin
    if (!kRst_b) begin
      dqPos_r <= '0;
    end else if (rdDrive) begin
      dqPos_r <= hold1_r;
    end
  end

  always_ff @(negedge kClk) begin
    if (!kRst_b) begin
      dqNeg_r <= '0;
      dqOe_r <= 1'b0;
    end else begin
      if (rdDrive) begin
        dqNeg_r <= hold0_r;
      end
      dqOe_r <= rdDrive;
    end
  end

  // output clocks are taken as phase-aligned with the main pair, so both
  // timing sources launch from the same edges; the tie only is tracked
  assign dqOut = kClk ? dqPos_r : dqNeg_r;
  assign dqOe = dqOe_r;

  ////////////////////////////////////////////////////////////
  // echo clocks, same launch edges as the data

  logic togP_r;
  logic togN_r;

  always_ff @(posedge kClk) begin
    if (!kRst_b) begin
      togP_r <= 1'b0;
    end else begin
      togP_r <= !togP_r;
    end
  end

  always_ff @(negedge kClk) begin
    if (!kRst_b) begin
      togN_r <= 1'b0;
    end else begin
      togN_r <= togP_r;
    end
  end

  assign echoTimingOut = togP_r ^ togN_r;
  assign echoTimingOutN = !(togP_r ^ togN_r);

  ////////////////////////////////////////////////////////////
  // checks

  a_rd_bus_window: assert property (
    @(posedge kClk) disable iff (!kRst_b)
    rdAcc |-> ##2 dqOe ##1 dqOe)
    else $error("read burst not driven for two cycles");

  a_wr_bus_free: assert property (
    @(posedge kClk) disable iff (!kRst_b)
    wrAcc |-> ##2 !dqOe ##1 !dqOe)
    else $error("bus driven during write beats");

  a_wr_two_cycles: assert property (
    @(posedge kClk) disable iff (!kRst_b)
    wrAcc |-> ##2 mp.we && !wrP3_r ##1 mp.we && wrP3_r)
    else $error("write burst not committed in cycles 2 and 3");

  a_load_high_idle: assert property (
    @(posedge kClk) disable iff (!kRst_b)
    loadStrobe_n |=> !rdP1_r && !wrP1_r)
    else $error("operation started with load strobe high");

  a_rw_select: assert property (
    @(posedge kClk) disable iff (!kRst_b)
    cmdTake && rwSelect |=> rdP1_r && !wrP1_r)
    else $error("read select did not start a read");

  a_byte_mask: assert property (
    @(posedge kClk) disable iff (!kRst_b)
    wrP1_r && (&byteWriteEnable_n) |=> mp.we && mp.beA == 4'h0)
    else $error("byte written with enable high");

  a_burst_wrap: assert property (
    @(posedge kClk) disable iff (!kRst_b)
    mp.we |-> mp.waB[1:0] == 2'(mp.waA[1:0] + 2'h1)
      && mp.waB[ADDR_W-1:2] == mp.waA[ADDR_W-1:2])
    else $error("burst pair not adjacent in its group");

  a_cmd_spacing: assert property (
    @(posedge kClk) disable iff (!kRst_b)
    cmdTake |=> !cmdTake)
    else $error("commands accepted on adjacent cycles");

  a_rd_fetch: assert property (
    @(posedge kClk) disable iff (!kRst_b)
    rdAcc |=> rdP1_r ##1 rdP2_r && !rdP1_r ##1 rdP3_r)
    else $error("read fetch pipeline broken");

  a_echo_run: assert property (
    @(posedge kClk) disable iff (!kRst_b)
    $past(kRst_b) |-> togP_r != $past(togP_r))
    else $error("echo clock stopped");

  a_tied_launch: assert property (
    @(posedge kClk) disable iff (!kRst_b)
    cTied_r && rdAcc |-> ##2 dqOe ##1 dqOe)
    else $error("read with tied output clocks not launched");

endmodule // ddr_burst4_cio_sram_port

`default_nettype wire

// >>> ddr_ctrl_model.sv
// controller model: queued commands, write beats, bus turn and echo checks
// assumes: kClk from the bench; the bench queues ops, then calls run
`default_nettype none

module ddr_ctrl_model
  import ddr_sram_pkg::*;
(
  input wire logic kClk,
  input wire logic [ddr_sram_pkg::DQ_W-1:0] dqOut,
  input wire logic dqOe,
  input wire logic echoTimingOut,
  input wire logic echoTimingOutN,
  output var logic rwSelect,
  output var logic loadStrobe_n,
  output var logic [ddr_sram_pkg::ADDR_W-1:0] addr,
  output var logic [ddr_sram_pkg::LANES-1:0] byteWriteEnable_n,
  output logic [ddr_sram_pkg::DQ_W-1:0] dqIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DQ_W-1:0] drv_r;
  logic drvOn_r;
  int rise[$];
  logic rd[$];
  logic live[$];
  logic [ADDR_W-1:0] adr[$];
  logic [4*DQ_W-1:0] dat[$];
  logic [4*LANES-1:0] ben[$];
  logic [DQ_W-1:0] got[$];
  int oeErr;
  int echoErr;

  // released bus shows the inverse of the last beat, never a stale copy
  assign dqIn = dqOe ? dqOut : (drvOn_r ? drv_r : ~drv_r);

  initial begin
    rwSelect = 1'b0;
    loadStrobe_n = 1'b1;
    addr = '0;
    byteWriteEnable_n = 4'hf;
    drv_r = '0;
    drvOn_r = 1'b0;
    oeErr = 0;
    echoErr = 0;
  end

  ////////////////////////////////////////
  task automatic add(input int r, input logic isRd, input logic ok,
                     input logic [ADDR_W-1:0] a, input logic [4*DQ_W-1:0] d,
                     input logic [4*LANES-1:0] b);
    rise.push_back(r);
    rd.push_back(isRd);
    live.push_back(ok);
    adr.push_back(a);
    dat.push_back(d);
    ben.push_back(b);
  endtask

  // one pass per half cycle; each value is set one half before it is taken
  task automatic run(input int nh);
    int h;
    int i;
    int p;
    logic lo;
    logic sel;
    logic on;
    logic oe;
    logic [ADDR_W-1:0] a;
    logic [DQ_W-1:0] d;
    logic [LANES-1:0] b;
    for (h = 0; h < nh; h++) begin
      if (h % 2 == 0) @(posedge kClk);
      else @(negedge kClk);
      lo = 1'b1;
      sel = 1'b0;
      a = '0;
      on = 1'b0;
      oe = 1'b0;
      d = drv_r;
      b = 4'hf;
      for (i = 0; i < rise.size(); i++) begin
        p = h - 2 * rise[i];
        if (p == -2 || p == -1) begin
          lo = 1'b0;
          sel = rd[i];
          a = adr[i];
        end
        if (live[i] && !rd[i] && p >= 1 && p <= 4) begin
          on = 1'b1;
          d = dat[i][(p-1)*DQ_W +: DQ_W];
          b = ben[i][(p-1)*LANES +: LANES];
        end
        if (live[i] && rd[i] && p >= 3 && p <= 6) oe = 1'b1;
      end
      loadStrobe_n <= lo;
      rwSelect <= sel;
      addr <= a;
      drv_r <= d;
      drvOn_r <= on;
      byteWriteEnable_n <= b;
      #3;
      if (dqOe !== oe) oeErr++;
      if (oe) got.push_back(dqOut);
      if (echoTimingOut !== (h % 2 == 0) || echoTimingOutN !== (h % 2 == 1)) echoErr++;
    end
    rise.delete();
    rd.delete();
    live.delete();
    adr.delete();
    dat.delete();
    ben.delete();
  endtask
endmodule // ddr_ctrl_model

`default_nettype wire

// >>> ddr_burst4_cio_sram_port_test.sv
// bench for the burst-of-four memory port: bursts, byte lanes, refusals
// assumes: ddr_ctrl_model on the link side; shadow memory in the bench
`default_nettype none

module ddr_burst4_cio_sram_port_test
  import ddr_sram_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk;
  logic rst_b;
  logic kClk;
  logic tied;
  logic dllDisable_n;
  logic rwSelect;
  logic loadStrobe_n;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0] bwn;
  logic [DQ_W-1:0] dqIn;
  logic [DQ_W-1:0] dqOut;
  logic dqOe;
  logic echoP;
  logic echoN;
  logic dllLocked;
  int errTotal;
  int testsRun;
  logic [DQ_W-1:0] mem [int];
  logic [DQ_W-1:0] exp[$];

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // link clock unrelated in phase to sys_clk
  initial begin
    kClk = 1'b0;
    #2.7;
    forever #6 kClk = ~kClk;
  end

  ddr_burst4_cio_sram_port ddr_burst4_cio_sram_port_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .kClk(kClk),
    .outClk(tied | kClk), .outClkN(tied | ~kClk), .dllDisable_n(dllDisable_n),
    .rwSelect(rwSelect), .loadStrobe_n(loadStrobe_n),
    .addressInputs(addr[ADDR_W-1:2]), .burstStartAddrLsb(addr[0]),
    .burstStartAddrMsb(addr[1]), .byteWriteEnable_n(bwn), .dqIn(dqIn),
    .dqOut(dqOut), .dqOe(dqOe), .echoTimingOut(echoP), .echoTimingOutN(echoN),
    .dllLocked(dllLocked));

  ddr_ctrl_model ddr_ctrl_model_i (
    .kClk(kClk), .dqOut(dqOut), .dqOe(dqOe), .echoTimingOut(echoP),
    .echoTimingOutN(echoN), .rwSelect(rwSelect), .loadStrobe_n(loadStrobe_n),
    .addr(addr), .byteWriteEnable_n(bwn), .dqIn(dqIn));

  ////////////////////////////////////////
  task automatic chk(input bit ok, input string m);
    testsRun++;
    if (!ok) begin
      errTotal++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  function automatic logic [4*DQ_W-1:0] pat(input logic [4:0] s);
    int k;
    int j;
    for (k = 0; k < 4; k++)
      for (j = 0; j < LANES; j++)
        pat[(k*LANES+j)*LANE_W +: LANE_W] = {s, 2'(j), 2'(k)};
  endfunction

  // shadow update: linear wrap in the two low bits, lane per enable
  task automatic wr(input int r, input logic [ADDR_W-1:0] a,
                    input logic [4*DQ_W-1:0] d, input logic [4*LANES-1:0] b);
    int k;
    int j;
    ddr_ctrl_model_i.add(r, 1'b0, 1'b1, a, d, b);
    for (k = 0; k < 4; k++)
      for (j = 0; j < LANES; j++)
        if (!b[k*LANES+j])
          mem[{a[ADDR_W-1:2], a[1:0] + 2'(k)}][j*LANE_W +: LANE_W] =
            d[(k*LANES+j)*LANE_W +: LANE_W];
  endtask

  task automatic rd(input int r, input logic [ADDR_W-1:0] a);
    int k;
    ddr_ctrl_model_i.add(r, 1'b1, 1'b1, a, '0, '1);
    for (k = 0; k < 4; k++)
      exp.push_back(mem[{a[ADDR_W-1:2], a[1:0] + 2'(k)}]);
  endtask

  task automatic go(input int nh);
    int k;
    ddr_ctrl_model_i.run(nh);
    chk(ddr_ctrl_model_i.got.size() == exp.size(), "beat count");
    for (k = 0; k < exp.size() && k < ddr_ctrl_model_i.got.size(); k++)
      chk(ddr_ctrl_model_i.got[k] === exp[k], "read data");
    chk(ddr_ctrl_model_i.oeErr == 0, "bus drive window");
    chk(ddr_ctrl_model_i.echoErr == 0, "echo timing");
    ddr_ctrl_model_i.oeErr = 0;
    ddr_ctrl_model_i.echoErr = 0;
    ddr_ctrl_model_i.got.delete();
    exp.delete();
  endtask

  // loop off also ties the output clock pair high
  task automatic rst(input logic dll);
    int n;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    dllDisable_n <= dll;
    tied <= ~dll;
    repeat (3) @(posedge sys_clk);
    #1 chk(dqOe === 1'b0 && dllLocked === 1'b0, "reset state");
    @(posedge sys_clk);
    rst_b <= 1'b1;
    n = 0;
    while (dllLocked !== 1'b1 && n < 700) begin
      @(posedge sys_clk);
      n++;
    end
    if (dll) chk(n >= DLL_LOCK_CYC && n <= DLL_LOCK_CYC + 8, "lock time");
    else chk(n == 700, "locked while disabled");
    repeat (4) @(posedge sys_clk);
  endtask

  ////////////////////////////////////////
  task automatic tBurst;
    wr(1, 20'h00100, pat(5'h01), '0);
    wr(3, 20'h00207, pat(5'h02), '0);
    go(16);
    rd(1, 20'h00102);
    rd(3, 20'h00205);
    go(16);
  endtask

  task automatic tBytes;
    wr(1, 20'h00100, pat(5'h03), {4'h0, 4'h5, 4'he, 4'hf});
    go(12);
    rd(1, 20'h00100);
    go(12);
  endtask

  // loads one cycle after a taken command must be ignored
  task automatic tRefuse;
    wr(1, 20'h00300, pat(5'h04), '0);
    ddr_ctrl_model_i.add(2, 1'b0, 1'b0, 20'h00100, '0, '0);
    go(14);
    rd(1, 20'h00100);
    ddr_ctrl_model_i.add(2, 1'b1, 1'b0, 20'h00300, '0, '1);
    rd(4, 20'h00300);
    go(20);
  endtask

  task automatic tDllOff;
    rst(1'b0);
    wr(1, 20'h00400, pat(5'h05), '0);
    go(12);
    rd(1, 20'h00400);
    go(12);
  endtask

  task automatic completeRun;
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // two lock waits of at most 700 cycles each dominate the run
  initial begin
    #400000;
    errTotal++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    completeRun();
  end

  initial begin
    rst_b = 1'b0;
    dllDisable_n = 1'b1;
    tied = 1'b0;
    errTotal = 0;
    testsRun = 0;
    rst(1'b1);
    tBurst();
    tBytes();
    tRefuse();
    tDllOff();
    completeRun();
  end
endmodule // ddr_burst4_cio_sram_port_test

`default_nettype wire
